// ### src/pbl_defines.svh
// Constants for the program block loader
`ifndef PBL_DEFINES_SVH
`define PBL_DEFINES_SVH
`define PBL_PORT_ADDR 8'hc8
`define PBL_HDR_BIT 15
`define PBL_SKIP_BIT 10
`define PBL_SEL_MSB 14
`define PBL_SEL_LSB 12
`define PBL_IDLE_MODE 4'h0
`define PBL_MAX_WORDS_STD 4'hc
`define PBL_MAX_WORDS_B4 4'he
`define PBL_RAMP_START 4'hb
`define PBL_W0_THRESH 4'h0
`define PBL_W0_FRAMING 4'h1
`define PBL_W0_REPEAT 4'h2
`define PBL_W0_RXCFG 4'ha
`define PBL_THRESH_RST 12'h005
`define PBL_TOL_RST 4'h2
`define PBL_PREAMBLE_RST 8'h00
`define PBL_REPEAT_RST 12'h000
`define PBL_ID_COUNT 6
`define PBL_ID_W 6
`define PBL_INVERT_BIT 1
`define PBL_IQ_BIT 0
`define PBL_CORRUPT_ERRS 5'h03
`define PBL_STD_PREAMBLE 8'h0c
`define PBL_PREAMBLE_MAX 8'h7f
`define PBL_SYM_POS3 2'h1
`define PBL_SYM_NEG3 2'h3
`define PBL_STATUS_IDLE 4'h0
`define PBL_STATUS_DROPPED 4'h3
`define PBL_CLK_NS 10
`define PBL_READY_MAX_NS 250000
`define PBL_READY_MAX_CYC (`PBL_READY_MAX_NS / `PBL_CLK_NS)
`endif

// ### src/pbl_pkg.sv
// Types shared by the program block loader
package pbl_pkg;
  typedef enum logic [2:0] {
    PBL_BLK_NONE,
    PBL_BLK0,
    PBL_BLK1,
    PBL_BLK2,
    PBL_BLK3,
    PBL_BLK4
  } pbl_block_t;
  typedef enum logic {
    PBL_HS_READY,
    PBL_HS_BUSY
  } pbl_hs_t;
endpackage

// ### src/pbl_frame_monitor.sv
// Frame sync error check and call drop counter
`timescale 1ns/100ps
`default_nettype none
`include "pbl_defines.svh"
module pbl_frame_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic fs_strobe,
  input wire logic [4:0] fs_errors,
  input wire logic [11:0] drop_threshold,
  input wire logic [3:0] fs_tolerance,
  output logic fs_valid,
  output logic call_drop
);
  logic [11:0] bad_run;
  logic [11:0] next_bad_run;
  logic next_fs_valid;
  logic next_call_drop;
  logic corrupt;

  always_comb begin
    corrupt = fs_errors >= `PBL_CORRUPT_ERRS;
    next_bad_run = bad_run;
    next_fs_valid = 1'b0;
    next_call_drop = 1'b0;
    if (fs_strobe) begin
      next_fs_valid = fs_errors <= {1'b0, fs_tolerance};
      if (!corrupt) begin
        next_bad_run = 12'h000;
      end else if (drop_threshold == 12'h000) begin
        next_bad_run = 12'h000;
      end else if (bad_run + 12'h001 >= drop_threshold) begin
        next_bad_run = 12'h000;
        next_call_drop = 1'b1;
      end else begin
        next_bad_run = bad_run + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bad_run <= 12'h000;
      fs_valid <= 1'b0;
      call_drop <= 1'b0;
    end else begin
      bad_run <= next_bad_run;
      fs_valid <= next_fs_valid;
      call_drop <= next_call_drop;
    end
  end

  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (rst);

  no_drop_zero_a: assert property (drop_threshold == 12'h000 |=> !call_drop)
    else $error("call dropped with zero threshold");
  clean_frame_a: assert property (fs_strobe && fs_errors < `PBL_CORRUPT_ERRS |=> !call_drop)
    else $error("clean frame sync caused a drop");
endmodule
`default_nettype wire

// ### src/pbl_preamble_gen.sv
// Extended preamble symbol generator
`timescale 1ns/100ps
`default_nettype none
`include "pbl_defines.svh"
module pbl_preamble_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_start,
  input wire logic symbol_tick,
  input wire logic [7:0] extra_symbols,
  output logic preamble_active,
  output logic [1:0] preamble_symbol
);
  logic [7:0] remaining;
  logic [7:0] next_remaining;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic next_active;
  logic [1:0] next_symbol;
  logic [7:0] extra_clamped;
  logic [7:0] extra_clamped_q;

  always_comb begin
    // Over-range counts are clamped rather than wrapped
    extra_clamped = (extra_symbols > `PBL_PREAMBLE_MAX) ? `PBL_PREAMBLE_MAX : extra_symbols;
    next_remaining = remaining;
    next_phase = phase;
    next_active = preamble_active;
    if (tx_start && !preamble_active) begin
      next_remaining = `PBL_STD_PREAMBLE + extra_clamped;
      next_phase = 2'h0;
      next_active = 1'b1;
    end else if (preamble_active && symbol_tick) begin
      next_phase = phase + 2'h1;
      next_remaining = remaining - 8'h01;
      next_active = remaining != 8'h01;
    end
    next_symbol = next_phase[1] ? `PBL_SYM_NEG3 : `PBL_SYM_POS3;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remaining <= 8'h00;
      phase <= 2'h0;
      preamble_active <= 1'b0;
      preamble_symbol <= `PBL_SYM_POS3;
    end else begin
      remaining <= next_remaining;
      phase <= next_phase;
      preamble_active <= next_active;
      preamble_symbol <= next_symbol;
    end
  end

  default clocking pre_cb @(posedge clk); endclocking
  default disable iff (rst);

  preamble_len_a: assert property (tx_start && !preamble_active |=> remaining == `PBL_STD_PREAMBLE + extra_clamped_q)
    else $error("preamble length not loaded");
  pattern_order_a: assert property (preamble_active && phase == 2'h1 && symbol_tick |=> preamble_symbol == `PBL_SYM_NEG3)
    else $error("preamble pattern out of order");

  // Start value copy for the length check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extra_clamped_q <= 8'h00;
    end else begin
      extra_clamped_q <= extra_clamped;
    end
  end
endmodule
`default_nettype wire

// ### src/pbl_loader.sv
// Program block loader with modem configuration decode
// Operation
// - Blocks are programmed only while mode control reads 0000.
// - Flag clears on a port write and sets again once the word is handled.
// - Host may stop early; unwritten words keep earlier values.
// - Bit 15 set resets word pointer; bits 14-12 select the block.
// - Bit 15 clear stores next word and advances, stopping at block end.
// - Block 3 header with bit 10 set starts the pointer at ramp table.
// - Codes 100-111 select blocks 0-3; bit 14 clear selects block 4.
// - Receiver drops call after the programmed count of consecutive corrupt frames.
// - A frame with 3 or more sync word bit errors is corrupt.
// - A dropped call posts the dropped status code and an event interrupt.
// - A zero drop threshold disables automatic call dropping.
// - Tolerance field sets maximum bit errors for a valid frame sync.
// - Transmit sends programmed extra +3 +3 -3 -3 symbols after standard 12.
// - Repeat word gives extra END frames (11-8) and HEADER frames (7-0).
// - Demod invert bit set inverts the FM demodulator signal.
// - Receive mode bit set selects quadrature, clear selects limiter-discriminator.
// - First six block 1 words hold six-bit own identifiers.
// - A zero first own identifier makes the receiver accept any user code.
`timescale 1ns/100ps
`default_nettype none
`include "pbl_defines.svh"
module pbl_loader
  import pbl_pkg::*;
#(
  parameter int HANDLE_CYCLES = 2,
  parameter int READY_MAX_CYCLES = `PBL_READY_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [3:0] mode_control,
  input wire logic fs_strobe,
  input wire logic [4:0] fs_errors,
  input wire logic tx_start,
  input wire logic symbol_tick,
  output logic program_ready_flag,
  output logic [11:0] call_drop_threshold,
  output logic [3:0] fs_tolerance,
  output logic [7:0] preamble_length,
  output logic [3:0] repeat_end_frames,
  output logic [7:0] repeat_header_frames,
  output logic demod_invert_bit,
  output logic quadrature_mode,
  output logic [`PBL_ID_COUNT*`PBL_ID_W-1:0] own_identifier_flat,
  output logic accept_any_user_code,
  output logic [3:0] modem_status,
  output logic event_irq,
  output logic fs_valid,
  output logic preamble_active,
  output logic [1:0] preamble_symbol
);
  // Busy counter is 16 bits and must finish inside the ready window
  if (HANDLE_CYCLES < 1 || HANDLE_CYCLES > READY_MAX_CYCLES || HANDLE_CYCLES > 65535) begin : g_bad_handle
    $error("HANDLE_CYCLES out of range");
  end

  localparam logic [11:0] REP_RST = `PBL_REPEAT_RST;

  pbl_hs_t hs;
  pbl_hs_t next_hs;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic next_ready;
  pbl_block_t blk;
  pbl_block_t next_blk;
  logic [3:0] ptr;
  logic [3:0] next_ptr;
  logic [11:0] next_thresh;
  logic [3:0] next_tol;
  logic [7:0] next_preamble;
  logic [3:0] next_rep_end;
  logic [7:0] next_rep_hdr;
  logic next_invert;
  logic next_iq;
  logic [`PBL_ID_W-1:0] own_identifier [`PBL_ID_COUNT];
  logic [`PBL_ID_W-1:0] next_own_identifier [`PBL_ID_COUNT];
  logic next_accept_any;
  logic [3:0] next_status;
  logic next_event;
  logic wr_hit;
  logic accept;
  logic st_en;
  pbl_block_t st_blk;
  logic [3:0] st_idx;
  logic call_drop;

  function automatic pbl_block_t decode_block(input logic [2:0] sel);
    pbl_block_t b;
    if (!sel[2]) begin
      b = PBL_BLK4;
    end else if (sel[1:0] == 2'h0) begin
      b = PBL_BLK0;
    end else if (sel[1:0] == 2'h1) begin
      b = PBL_BLK1;
    end else if (sel[1:0] == 2'h2) begin
      b = PBL_BLK2;
    end else begin
      b = PBL_BLK3;
    end
    return b;
  endfunction

  function automatic logic [3:0] block_limit(input pbl_block_t b);
    return (b == PBL_BLK4) ? `PBL_MAX_WORDS_B4 : `PBL_MAX_WORDS_STD;
  endfunction

  // Handshake: the word is taken at once, the flag models the handling time
  always_comb begin
    wr_hit = reg_wr && (reg_addr == `PBL_PORT_ADDR);
    // Writes while busy or outside idle are dropped, not queued
    accept = wr_hit && program_ready_flag && (mode_control == `PBL_IDLE_MODE);
    next_hs = hs;
    next_busy_cnt = busy_cnt;
    next_ready = program_ready_flag;
    case (hs)
      PBL_HS_READY: begin
        if (accept) begin
          next_hs = PBL_HS_BUSY;
          next_ready = 1'b0;
          next_busy_cnt = 16'(HANDLE_CYCLES);
        end
      end
      PBL_HS_BUSY: begin
        next_busy_cnt = busy_cnt - 16'h0001;
        if (busy_cnt == 16'h0001) begin
          next_hs = PBL_HS_READY;
          next_ready = 1'b1;
        end
      end
      default: begin
        next_hs = PBL_HS_READY;
        next_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs <= PBL_HS_READY;
      busy_cnt <= 16'h0000;
      program_ready_flag <= 1'b1;
    end else begin
      hs <= next_hs;
      busy_cnt <= next_busy_cnt;
      program_ready_flag <= next_ready;
    end
  end

  // Pointer and block storage
  always_comb begin
    next_blk = blk;
    next_ptr = ptr;
    st_en = 1'b0;
    st_blk = blk;
    st_idx = ptr;
    if (accept) begin
      if (reg_wdata[`PBL_HDR_BIT]) begin
        next_blk = decode_block(reg_wdata[`PBL_SEL_MSB:`PBL_SEL_LSB]);
        st_blk = next_blk;
        if (next_blk == PBL_BLK3 && reg_wdata[`PBL_SKIP_BIT]) begin
          next_ptr = `PBL_RAMP_START;
        end else begin
          st_en = 1'b1;
          st_idx = 4'h0;
          next_ptr = 4'h1;
        end
      end else if (blk != PBL_BLK_NONE && ptr < block_limit(blk)) begin
        st_en = 1'b1;
        next_ptr = ptr + 4'h1;
      end
    end
    // Only written fields change; the rest hold earlier values
    next_thresh = call_drop_threshold;
    next_tol = fs_tolerance;
    next_preamble = preamble_length;
    next_rep_end = repeat_end_frames;
    next_rep_hdr = repeat_header_frames;
    next_invert = demod_invert_bit;
    next_iq = quadrature_mode;
    for (int i = 0; i < `PBL_ID_COUNT; i++) begin
      next_own_identifier[i] = own_identifier[i];
      if (st_en && st_blk == PBL_BLK1 && st_idx == 4'(i)) begin
        next_own_identifier[i] = reg_wdata[`PBL_ID_W-1:0];
      end
    end
    if (st_en && st_blk == PBL_BLK0) begin
      if (st_idx == `PBL_W0_THRESH) begin
        next_thresh = reg_wdata[11:0];
      end else if (st_idx == `PBL_W0_FRAMING) begin
        next_tol = reg_wdata[11:8];
        next_preamble = reg_wdata[7:0];
      end else if (st_idx == `PBL_W0_REPEAT) begin
        next_rep_end = reg_wdata[11:8];
        next_rep_hdr = reg_wdata[7:0];
      end else if (st_idx == `PBL_W0_RXCFG) begin
        next_invert = reg_wdata[`PBL_INVERT_BIT];
        next_iq = reg_wdata[`PBL_IQ_BIT];
      end
    end
    next_accept_any = next_own_identifier[0] == 6'h00;
    next_status = call_drop ? `PBL_STATUS_DROPPED : modem_status;
    next_event = call_drop;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk <= PBL_BLK_NONE;
      ptr <= 4'h0;
      call_drop_threshold <= `PBL_THRESH_RST;
      fs_tolerance <= `PBL_TOL_RST;
      preamble_length <= `PBL_PREAMBLE_RST;
      repeat_end_frames <= REP_RST[11:8];
      repeat_header_frames <= REP_RST[7:0];
      demod_invert_bit <= 1'b0;
      quadrature_mode <= 1'b0;
      for (int i = 0; i < `PBL_ID_COUNT; i++) begin
        own_identifier[i] <= 6'h00;
      end
      accept_any_user_code <= 1'b1;
      modem_status <= `PBL_STATUS_IDLE;
      event_irq <= 1'b0;
    end else begin
      blk <= next_blk;
      ptr <= next_ptr;
      call_drop_threshold <= next_thresh;
      fs_tolerance <= next_tol;
      preamble_length <= next_preamble;
      repeat_end_frames <= next_rep_end;
      repeat_header_frames <= next_rep_hdr;
      demod_invert_bit <= next_invert;
      quadrature_mode <= next_iq;
      own_identifier <= next_own_identifier;
      accept_any_user_code <= next_accept_any;
      modem_status <= next_status;
      event_irq <= next_event;
    end
  end

  for (genvar g = 0; g < `PBL_ID_COUNT; g++) begin : g_id_out
    assign own_identifier_flat[g*`PBL_ID_W +: `PBL_ID_W] = own_identifier[g];
  end

  pbl_frame_monitor u_monitor (
    .clk(clk),
    .rst(rst),
    .fs_strobe(fs_strobe),
    .fs_errors(fs_errors),
    .drop_threshold(call_drop_threshold),
    .fs_tolerance(fs_tolerance),
    .fs_valid(fs_valid),
    .call_drop(call_drop)
  );

  pbl_preamble_gen u_preamble (
    .clk(clk),
    .rst(rst),
    .tx_start(tx_start),
    .symbol_tick(symbol_tick),
    .extra_symbols(preamble_length),
    .preamble_active(preamble_active),
    .preamble_symbol(preamble_symbol)
  );

  // Helper: length of the current low period of the ready flag
  logic [15:0] low_run;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_run <= 16'h0000;
    end else begin
      low_run <= program_ready_flag ? 16'h0000 : low_run + 16'h0001;
    end
  end

  default clocking ld_cb @(posedge clk); endclocking
  default disable iff (rst);

  ready_clear_a: assert property (accept |=> !program_ready_flag)
    else $error("ready flag not cleared by port write");
  ready_return_a: assert property (low_run <= 16'(HANDLE_CYCLES))
    else $error("ready flag low too long");
  idle_gate_a: assert property (wr_hit && mode_control != `PBL_IDLE_MODE |=> $stable(ptr) && $stable(blk))
    else $error("port write taken outside idle");
  header_ptr_a: assert property (accept && reg_wdata[15] && !reg_wdata[10] |=> ptr == 4'h1)
    else $error("header did not reset pointer");
  skip_ptr_a: assert property (accept && reg_wdata[15:12] == 4'hf && reg_wdata[10] |=> ptr == `PBL_RAMP_START)
    else $error("ramp skip not taken");
  ptr_bound_a: assert property (blk != PBL_BLK4 |-> ptr <= `PBL_MAX_WORDS_STD)
    else $error("pointer ran past block end");
  drop_status_a: assert property (call_drop |=> modem_status == `PBL_STATUS_DROPPED && event_irq)
    else $error("call drop not reported");
  block4_sel_a: assert property (accept && reg_wdata[15] && !reg_wdata[14] |=> blk == PBL_BLK4)
    else $error("block 4 decode wrong");
endmodule
`default_nettype wire

// ### bench/pbl_host_model.sv
// Host model that loads program blocks through the port
`timescale 1ns/100ps
`default_nettype none
module pbl_host_model (
  input wire logic clk,
  input wire logic program_ready_flag,
  output var logic [7:0] reg_addr,
  output var logic reg_wr,
  output var logic [15:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // No other interrupt or converter traffic while loading
  // Callers send words in block order and stay within counts
  task automatic write_word(input logic [7:0] addr, input logic [15:0] w,
                            output int low_cycles, output logic ok);
    int n;
    low_cycles = 0;
    for (n = 0; n < 64 && program_ready_flag !== 1'b1; n++) @(negedge clk);
    ok = 1'b0;
    // Never write while the flag is low, even after a timeout
    if (program_ready_flag !== 1'b1) return;
    reg_addr = addr;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released lines show the inverse so stale data never looks valid
    reg_addr = ~addr;
    reg_wdata = ~w;
    for (n = 0; n < 4 && program_ready_flag !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 64 && program_ready_flag === 1'b0; n++) begin
      low_cycles++;
      @(negedge clk);
    end
    ok = (program_ready_flag === 1'b1);
  endtask
endmodule
`default_nettype wire

// ### bench/pbl_testbench.sv
// Self-checking bench for the program block loader
`timescale 1ns/100ps
`default_nettype none
`include "pbl_defines.svh"
module testbench;
  localparam int HANDLE = 3;
  logic clk;
  logic rst;
  logic [3:0] mode_control;
  logic fs_strobe;
  logic [4:0] fs_errors;
  logic tx_start;
  logic symbol_tick;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic program_ready_flag;
  logic [11:0] call_drop_threshold;
  logic [3:0] fs_tolerance;
  logic [7:0] preamble_length;
  logic [3:0] repeat_end_frames;
  logic [7:0] repeat_header_frames;
  logic demod_invert_bit;
  logic quadrature_mode;
  logic [35:0] own_identifier_flat;
  logic accept_any_user_code;
  logic [3:0] modem_status;
  logic event_irq;
  logic fs_valid;
  logic preamble_active;
  logic [1:0] preamble_symbol;
  int num_errors = 0;
  int samples_checked = 0;
  logic [15:0] hdrs [4] = '{16'h8005, 16'he005, 16'hf405, 16'hf005};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  pbl_loader #(.HANDLE_CYCLES(HANDLE), .READY_MAX_CYCLES(8)) uut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .mode_control(mode_control), .fs_strobe(fs_strobe),
    .fs_errors(fs_errors), .tx_start(tx_start), .symbol_tick(symbol_tick),
    .program_ready_flag(program_ready_flag), .call_drop_threshold(call_drop_threshold),
    .fs_tolerance(fs_tolerance), .preamble_length(preamble_length),
    .repeat_end_frames(repeat_end_frames), .repeat_header_frames(repeat_header_frames),
    .demod_invert_bit(demod_invert_bit), .quadrature_mode(quadrature_mode),
    .own_identifier_flat(own_identifier_flat),
    .accept_any_user_code(accept_any_user_code), .modem_status(modem_status),
    .event_irq(event_irq), .fs_valid(fs_valid), .preamble_active(preamble_active),
    .preamble_symbol(preamble_symbol)
  );

  pbl_host_model host (
    .clk(clk), .program_ready_flag(program_ready_flag),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata)
  );

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr_at(input logic [7:0] addr, input logic [15:0] w, input int exp_low);
    int lc;
    logic ok;
    host.write_word(addr, w, lc, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    check("ready_low_cycles", 36'(lc), 36'(exp_low));
  endtask

  task automatic wr(input logic [15:0] w);
    wr_at(`PBL_PORT_ADDR, w, HANDLE);
  endtask

  task automatic frame(input logic [4:0] err, output logic valid, output logic irq);
    fs_strobe = 1'b1;
    fs_errors = err;
    @(negedge clk);
    fs_strobe = 1'b0;
    valid = fs_valid;
    @(negedge clk);
    irq = event_irq;
  endtask

  initial begin
    logic v;
    logic q;
    int k;
    int bad;
    rst = 1'b1;
    mode_control = 4'h0;
    fs_strobe = 1'b0;
    fs_errors = 5'h00;
    tx_start = 1'b0;
    symbol_tick = 1'b0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check("ready_rst", program_ready_flag, 1'b1);
    check("thresh_rst", call_drop_threshold, 12'h005);
    check("pre_rst", preamble_length, 8'h00);
    check("any_rst", accept_any_user_code, 1'b1);
    check("quad_rst", quadrature_mode, 1'b0);
    $display("test reset done");

    wr(16'hc007);
    check("thresh", call_drop_threshold, 12'h007);
    wr(16'h0305);
    check("tol_pre", {fs_tolerance, preamble_length}, 12'h305);
    wr(16'h0208);
    check("repeat", {repeat_end_frames, repeat_header_frames}, 12'h208);
    for (k = 3; k < 10; k++) wr(16'h0000);
    wr(16'h0003);
    check("inv_quad", {demod_invert_bit, quadrature_mode}, 2'h3);
    wr(16'h0000);
    check("word11", {demod_invert_bit, quadrature_mode}, 2'h3);
    $display("test block0 done");

    wr(16'hc009);
    check("partial", {call_drop_threshold, fs_tolerance, preamble_length}, 24'h009305);
    for (k = 0; k < 4; k++) begin
      wr(hdrs[k]);
      wr(16'h0004);
      check("other_blk", {call_drop_threshold, fs_tolerance}, 16'h0093);
    end
    mode_control = 4'h1;
    wr_at(`PBL_PORT_ADDR, 16'hc00a, 0);
    mode_control = 4'h0;
    wr_at(8'hc9, 16'hc00a, 0);
    check("refused", call_drop_threshold, 12'h009);
    $display("test select done");

    wr(16'hd015);
    wr(16'h002a);
    check("ids", {own_identifier_flat[11:0], accept_any_user_code}, 13'h152a);
    check("ids_hi", own_identifier_flat[35:12], 24'h000000);
    wr(16'hd000);
    check("id0_zero", {own_identifier_flat[11:0], accept_any_user_code}, 13'h1501);
    $display("test block1 done");

    wr(16'hc000);
    frame(5'h03, v, q);
    check("fs_valid_tol", v, 1'b1);
    frame(5'h04, v, q);
    check("fs_valid_over", v, 1'b0);
    for (k = 0; k < 6; k++) frame(5'h05, v, q);
    check("no_drop", {modem_status, q}, 5'h00);
    wr(16'hc002);
    frame(5'h04, v, q);
    frame(5'h02, v, q);
    frame(5'h03, v, q);
    check("run_reset", q, 1'b0);
    frame(5'h07, v, q);
    check("drop_irq", q, 1'b1);
    check("drop_status", modem_status, 4'h3);
    frame(5'h00, v, q);
    check("irq_pulse", q, 1'b0);
    $display("test frames done");

    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    check("pre_start", {preamble_active, preamble_symbol}, 3'h5);
    bad = 0;
    k = 0;
    while (k < 300 && preamble_active === 1'b1) begin
      symbol_tick = 1'b1;
      @(negedge clk);
      symbol_tick = 1'b0;
      k++;
      if (preamble_active === 1'b1 && preamble_symbol !== ((k % 4 < 2) ? 2'h1 : 2'h3)) begin
        bad++;
      end
      @(negedge clk);
    end
    check("pre_symbols", 36'(bad), 36'(0));
    check("pre_ticks", 36'(k), 36'(12 + 5));
    $display("test preamble done");
    end_sim();
  end
endmodule
`default_nettype wire
